/* File: core/keypad_interrupt_latch.sv */
// Keypad wake and interrupt latch with an AXI4-Lite register slave
// Summary of operation
// - Each enable bit picks its own pin as a key input.
// - Enabling a pin turns on its internal pull-up.
// - Latch a request when an enabled pin falls after all were high.
// - Edge mode: no new latch while another enabled pin is low.
// - Level mode: clear needs acknowledge and all enabled pins high, any order.
// - Edge mode: acknowledge clears the latch at once.
// - Vector fetch or a one written to the strobe acknowledges.
// - Acknowledge leaves detection alone; later falling edge relatches.
// - Unmasked latched request makes the CPU take the keypad vector.
// - Reset clears latch and sense select, even with a pin low.
// - Pending flag reads the request regardless of mask; reset clears.
// - Enable forces pin to input; read back only with direction zero.
// - Status/control bits 7 to 4 always read zero.
// - Acknowledge strobe is write-only, reads zero, reset cleared.
// - Mask one blocks requests to the CPU; reset clears it.
// - Sense select one: edges and levels; zero: edges only.
// - Enable bit one lets its pin request; reset clears all.
// - Unit stays active in wait; unmasked request wakes.
// - Unit stays active in stop; unmasked request wakes.
// - In break, strobe acknowledge ignored unless clear enable set; vector fetch still acknowledges.
`timescale 1ns/1ps
module keypad_interrupt_latch #(
  parameter int unsigned KEYS = keypad_pkg::NUM_KEYS
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [keypad_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [keypad_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [KEYS-1:0]                key_input_pin,
  input  wire keypad_pkg::port_ctl_t          port_ctl,
  input  wire logic                           vector_fetch,
  input  wire logic                           break_state,
  output logic                                cpu_irq,
  output logic                                wake_request,
  output logic [KEYS-1:0]                     pin_pullup_en,
  output logic [KEYS-1:0]                     pin_output_en_n,
  output logic [KEYS-1:0]                     pin_read_data
);
  import keypad_pkg::*;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  logic [KEYS-1:0] pin_meta_q;
  logic [KEYS-1:0] pin_sync_q;
  logic [KEYS-1:0] pin_enable_q;
  ctrl_t           ctrl_q;
  logic            latch_q;
  logic            all_high_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= key_input_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // A disabled pin is treated as high so it never blocks or triggers
  function automatic logic any_low(input logic [KEYS-1:0] pins,
                                   input logic [KEYS-1:0] en);
    any_low = |(~pins & en);
  endfunction : any_low

  logic any_low_now;
  logic fall_event;
  assign any_low_now = any_low(pin_sync_q, pin_enable_q);
  // Low after all-high; a pin already low blocks new edges
  assign fall_event  = any_low_now && all_high_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      all_high_q <= 1'b1;
    end else begin
      all_high_q <= !any_low_now;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic                  aw_held_q;
  logic                  w_held_q;
  logic [ADDR_W-1:0]     awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_fire;
  logic                  ack_write;
  logic                  ack_pulse;

  logic                  aw_held_d;
  logic                  w_held_d;
  logic                  bvalid_d;
  logic                  rvalid_d;

  assign wr_fire = aw_held_q && w_held_q;
  // Ready comes from a flop, so it is worked out from next-cycle channel state
  assign aw_held_d = !wr_fire && (aw_held_q || (s_axi_awvalid && s_axi_awready));
  assign w_held_d  = !wr_fire && (w_held_q || (s_axi_wvalid && s_axi_wready));
  assign bvalid_d  = wr_fire || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_d  = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready  <= !w_held_d && !bvalid_d;
      s_axi_arready <= !rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
  end

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == STATUS_CTRL_ADDR) || (a == PIN_ENABLE_ADDR) ||
                  (a == BREAK_CTRL_ADDR);
  endfunction : addr_mapped

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic lane0_write;
  assign lane0_write = wr_fire && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (lane0_write && awaddr_q == STATUS_CTRL_ADDR) begin
      ctrl_q.trig_sense <= wdata_q[TRIG_SENSE_BIT];
      ctrl_q.req_mask   <= wdata_q[REQ_MASK_BIT];
    end else if (lane0_write && awaddr_q == BREAK_CTRL_ADDR) begin
      ctrl_q.break_clear_enable <= wdata_q[BREAK_CLR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_enable_q <= PIN_ENABLE_RST;
    end else if (lane0_write && awaddr_q == PIN_ENABLE_ADDR) begin
      pin_enable_q <= wdata_q[KEYS-1:0];
    end
  end

  // Strobe is never stored, so it cannot read back
  assign ack_write = lane0_write && awaddr_q == STATUS_CTRL_ADDR &&
                     wdata_q[ACK_STROBE_BIT];
  // Break blocks the strobe acknowledge unless clearing is allowed; vector fetch still acknowledges
  assign ack_pulse = vector_fetch ||
                     (ack_write && (!break_state || ctrl_q.break_clear_enable));

  // ------------------------------------------------------------
  // Request latch
  // ------------------------------------------------------------
  logic ack_seen_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q    <= 1'b0;
      ack_seen_q <= 1'b0;
    end else if (fall_event) begin
      // New edge wins over a same-cycle acknowledge
      latch_q    <= 1'b1;
      ack_seen_q <= 1'b0;
    end else if (!ctrl_q.trig_sense) begin
      ack_seen_q <= 1'b0;
      if (ack_pulse) begin
        latch_q <= 1'b0;
      end
    end else if (latch_q) begin
      // Level mode: both events, either order
      if ((ack_pulse || ack_seen_q) && !any_low_now) begin
        latch_q    <= 1'b0;
        ack_seen_q <= 1'b0;
      end else if (ack_pulse) begin
        ack_seen_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs to CPU and port
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq      <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      // Clock keeps running in wait and stop, so the latch stays live
      cpu_irq      <= latch_q && !ctrl_q.req_mask;
      wake_request <= latch_q && !ctrl_q.req_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_pullup_en   <= '0;
      pin_output_en_n <= '1;
      pin_read_data   <= '0;
    end else begin
      pin_pullup_en   <= pin_enable_q;
      pin_output_en_n <= ~(port_ctl.dir & ~pin_enable_q);
      pin_read_data   <= pin_sync_q & ~port_ctl.dir;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      STATUS_CTRL_ADDR: begin
        // Upper nibble and strobe stay zero
        rd_word[PEND_FLAG_BIT]  = latch_q;
        rd_word[REQ_MASK_BIT]   = ctrl_q.req_mask;
        rd_word[TRIG_SENSE_BIT] = ctrl_q.trig_sense;
      end
      PIN_ENABLE_ADDR: rd_word[KEYS-1:0] = pin_enable_q;
      BREAK_CTRL_ADDR: rd_word[BREAK_CLR_BIT] = ctrl_q.break_clear_enable;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= addr_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_edge_latches: assert property (@(posedge aclk) disable iff (!aresetn)
    fall_event |=> latch_q)
    else $error("falling edge did not latch");
  a_edge_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!latch_q && !all_high_q && !ack_pulse) |=> !latch_q)
    else $error("latch set while a pin already low");
  a_edge_ack_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q.trig_sense && ack_pulse && !fall_event) |=> !latch_q)
    else $error("edge mode ack did not clear");
  a_level_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.trig_sense && latch_q && any_low_now) |=> latch_q)
    else $error("level request dropped while pin low");
  a_break_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    // A level-mode ack taken before break may still finish its clear
    (latch_q && !vector_fetch && !ack_seen_q && break_state &&
     !ctrl_q.break_clear_enable) |=> latch_q)
    else $error("latch cleared in protected break");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_irq == $past(latch_q && !ctrl_q.req_mask))
    else $error("cpu request not gated latch");
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> (!latch_q && !ctrl_q.trig_sense && !cpu_irq))
    else $error("reset left request or sense set");
  a_pullup_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 pin_pullup_en == $past(pin_enable_q))
    else $error("pull-up not following enable");
  a_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_CTRL_ADDR) |=>
      (s_axi_rdata[31:PEND_FLAG_BIT+1] == '0 && !s_axi_rdata[ACK_STROBE_BIT]))
    else $error("status unused or strobe bits read back as one");
  a_pending_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_CTRL_ADDR) |=>
      (s_axi_rdata[PEND_FLAG_BIT] == $past(latch_q)))
    else $error("pending flag not showing the request");
  a_level_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.trig_sense && latch_q && (ack_pulse || ack_seen_q) && !any_low_now) |=> !latch_q)
    else $error("level request kept after ack and release");
  a_fetch_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_fetch && !ctrl_q.trig_sense && !fall_event) |=> !latch_q)
    else $error("vector fetch did not acknowledge");
  a_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_request == $past(latch_q && !ctrl_q.req_mask))
    else $error("wake request not gated latch");
  a_key_input: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ((~pin_output_en_n & $past(pin_enable_q)) == '0))
    else $error("key enabled pin still driven");
endmodule : keypad_interrupt_latch

/* File: core/keypad_pkg.sv */
// Package: register map, field layout and carriers for the keypad interrupt latch
package keypad_pkg;
  localparam int unsigned NUM_KEYS      = 5;
  localparam int unsigned ADDR_W        = 4;
  // Byte addresses on the register bus
  localparam logic [3:0]  STATUS_CTRL_ADDR = 4'h0;
  localparam logic [3:0]  PIN_ENABLE_ADDR  = 4'h4;
  localparam logic [3:0]  BREAK_CTRL_ADDR  = 4'h8;
  // Status/control field positions
  localparam int unsigned TRIG_SENSE_BIT  = 0;
  localparam int unsigned REQ_MASK_BIT    = 1;
  localparam int unsigned ACK_STROBE_BIT  = 2;
  localparam int unsigned PEND_FLAG_BIT   = 3;
  // Break control field position
  localparam int unsigned BREAK_CLR_BIT   = 0;
  // Reset values and response codes
  localparam logic [4:0]  PIN_ENABLE_RST  = 5'h00;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam logic [1:0]  AXI_SLVERR      = 2'h2;

  typedef struct packed {
    logic        trig_sense;
    logic        req_mask;
    logic        break_clear_enable;
  } ctrl_t;

  typedef struct packed {
    logic [NUM_KEYS-1:0] dir;
    logic [NUM_KEYS-1:0] dat;
  } port_ctl_t;
endpackage : keypad_pkg

/* File: verif/keypad_switches.sv */
// Keypad switch model: a pressed key pulls its pin low
`timescale 1ns/1ps
module keypad_switches (
  input  wire logic       aclk,
  input  wire logic [4:0] press,
  input  wire logic [4:0] pullup_en,
  output logic      [4:0] pin_level
);
  logic [4:0] float_q;

  initial float_q = 5'h00;

  // A pin without pull-up wanders each cycle so it can never pose as a steady high
  always @(posedge aclk) begin
    float_q <= ~float_q;
  end

  assign pin_level = ~press & (pullup_en | float_q);
endmodule : keypad_switches

/* File: verif/tb_keypad_interrupt_latch.sv */
// Testbench: register tasks and key pin scenarios for the keypad latch
`timescale 1ns/1ps
module tb_keypad_interrupt_latch;
  import keypad_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cpu_irq, wake_request;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [4:0]  press = 5'h00, pins, pull_en, oen_n, pin_rd;
  port_ctl_t   port_ctl = '0;
  logic        vector_fetch = 1'b0, break_state = 1'b0;
  int          errors = 0, total_checks = 0;

  always #4 aclk = ~aclk;

  keypad_interrupt_latch keypad_interrupt_latch_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_input_pin(pins), .port_ctl(port_ctl), .vector_fetch(vector_fetch),
    .break_state(break_state), .cpu_irq(cpu_irq), .wake_request(wake_request),
    .pin_pullup_en(pull_en), .pin_output_en_n(oen_n), .pin_read_data(pin_rd));

  keypad_switches keypad_switches_inst (
    .aclk(aclk), .press(press), .pullup_en(pull_en), .pin_level(pins));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    // Response ready stays up, so back-to-back calls never drive it twice in one step
    bs = bresp;
    if (n >= 40) errors++;
  endtask : wr

  task automatic rd_reg(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rd = rdata;
    rs = rresp;
    if (n >= 40) errors++;
  endtask : rd_reg

  task automatic st(input string what, input logic [7:0] exp);
    rd_reg(STATUS_CTRL_ADDR);
    check(what, {24'h0, exp}, rd);
  endtask : st

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    errors++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st("status reset", 8'h00);
    rd_reg(PIN_ENABLE_ADDR);
    check("enable reset", 32'h0, rd);
    check("oe reset", 32'h1f, 32'(oen_n));
    rd_reg(4'hc);
    check("unmapped resp", 32'(AXI_SLVERR), 32'(rs));
    wr(4'hc, 32'h0);
    check("unmapped wresp", 32'(AXI_SLVERR), 32'(bs));
    $display("test reset done");
    // ----------------------------------------
    // Setup: mask, enable, settle, ack, unmask
    // ----------------------------------------
    port_ctl.dir <= 5'h1f;
    wr(STATUS_CTRL_ADDR, 32'h02);
    check("wresp okay", 32'(AXI_OKAY), 32'(bs));
    check("oe drive", 32'h00, 32'(oen_n));
    wr(PIN_ENABLE_ADDR, 32'h1f);
    cyc(4);
    wr(STATUS_CTRL_ADDR, 32'h06);
    wr(STATUS_CTRL_ADDR, 32'h00);
    check("pullups", 32'h1f, 32'(pull_en));
    check("oe forced in", 32'h1f, 32'(oen_n));
    check("pin read blocked", 32'h00, 32'(pin_rd));
    st("status init", 8'h00);
    port_ctl.dir <= 5'h00;
    // Edge mode: latch, blocked edge, ack, relatch
    press <= 5'h01;
    cyc(6);
    check("irq edge", 32'h1, 32'(cpu_irq));
    check("wake edge", 32'h1, 32'(wake_request));
    check("pin read", 32'h1e, 32'(pin_rd));
    st("pending", 8'h08);
    press <= 5'h03;
    wr(STATUS_CTRL_ADDR, 32'h04);
    cyc(6);
    st("edge blocked", 8'h00);
    press <= 5'h00;
    cyc(6);
    press <= 5'h04;
    cyc(6);
    st("relatch", 8'h08);
    wr(STATUS_CTRL_ADDR, 32'h02);
    cyc(2);
    check("irq masked", 32'h0, 32'(cpu_irq));
    check("wake masked", 32'h0, 32'(wake_request));
    st("pending masked", 8'h0a);
    wr(STATUS_CTRL_ADDR, 32'h00);
    vector_fetch <= 1'b1;
    @(posedge aclk);
    vector_fetch <= 1'b0;
    cyc(3);
    st("fetch ack", 8'h00);
    press <= 5'h00;
    $display("test edge done");
    // Level mode in both orders
    wr(STATUS_CTRL_ADDR, 32'h01);
    press <= 5'h08;
    cyc(6);
    wr(STATUS_CTRL_ADDR, 32'h05);
    cyc(2);
    st("level held", 8'h09);
    press <= 5'h00;
    cyc(6);
    st("level clear", 8'h01);
    press <= 5'h08;
    cyc(6);
    press <= 5'h00;
    cyc(6);
    st("level kept", 8'h09);
    wr(STATUS_CTRL_ADDR, 32'h05);
    st("level acked", 8'h01);
    $display("test level done");
    // Break protection of the software ack
    wr(STATUS_CTRL_ADDR, 32'h00);
    press <= 5'h10;
    cyc(6);
    break_state <= 1'b1;
    wr(STATUS_CTRL_ADDR, 32'h04);
    st("break guard", 8'h08);
    wr(BREAK_CTRL_ADDR, 32'h01);
    wr(STATUS_CTRL_ADDR, 32'h04);
    break_state <= 1'b0;
    cyc(2);
    st("break clear", 8'h00);
    press <= 5'h00;
    $display("test break done");
    // A disabled pin may wander without raising a request
    wr(PIN_ENABLE_ADDR, 32'h0f);
    cyc(8);
    st("disabled pin", 8'h00);
    $display("test enable done");
    // Reset in mid-run with a key held low in level mode
    wr(STATUS_CTRL_ADDR, 32'h01);
    press <= 5'h01;
    cyc(6);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("irq after reset", 32'h0, 32'(cpu_irq));
    st("status after reset", 8'h00);
    $display("test reset again done");
    finish_test();
  end
endmodule : tb_keypad_interrupt_latch
